// ===== stream_fifo.sv
// Purpose: Shared constants of the polarity fix logic and a generic valid/ready FIFO.
// Assumes: One clock, synchronous active-high reset, clock enable freezes all state.
// Notes:   The package comes first so every later file can reference it.
`timescale 1ns/1ps
`default_nettype none

package polarity_fix_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IDLE_COUNT_OFS = 8'h08;
  localparam logic [7:0] RX_EVENT_OFS = 8'h0c;

  // Control fields
  localparam int CTRL_DETECT_EN_BIT = 0;
  localparam int CTRL_CAPTURE_EN_BIT = 1;
  localparam logic CTRL_DETECT_EN_RST = 1'b1;
  localparam logic CTRL_CAPTURE_EN_RST = 1'b1;

  // Status fields
  localparam int STAT_INVERTED_BIT = 0;
  localparam int STAT_STANDBY_BIT = 1;
  localparam int STAT_DETECTING_BIT = 2;
  localparam int STAT_OVERFLOW_BIT = 3;
  localparam int STAT_FIFO_VALID_BIT = 4;

  // Receive event word layout
  localparam int EVT_WIDTH = 16;
  localparam int EVT_LEVEL_BIT = 15;
  localparam int EVT_GAP_W = 15;
  localparam int EVT_VALID_BIT = 16;
  localparam int FIFO_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int TICK_W = 8;
  localparam int FAILSAFE_IDLE_TIME_MIN_MS = 44;
  localparam int FAILSAFE_IDLE_TIME_MAX_MS = 76;
  localparam int FAILSAFE_MIN_TICKS = FAILSAFE_IDLE_TIME_MIN_MS * 1000 / TICK_US;
  localparam int IDLE_W = 17;
  localparam int STANDBY_NS = 300;
  localparam int STANDBY_CYCLES = (STANDBY_NS * CLK_MHZ + 999) / 1000;
  localparam int STANDBY_W = 7;
endpackage : polarity_fix_pkg

module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Honest flags from the fill count
  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady && ce;
  assign pop = outValid && outReady && ce;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : stream_fifo

`default_nettype wire

// ===== polarity_fix_logic.sv
// Purpose: Bus polarity detection and correction for a half-duplex transceiver node.
// Assumes: 200 MHz clk, synchronous active-high rst stands for power-up, pins synchronous.
// Notes:   Registers on AHB-Lite, zero wait states while ce is high; receive edges are logged in a FIFO.
//
// What this block does and what it expects of the nodes on the bus
// [RQ1] After reset no inversion is applied; polarity is assumed correct.
// [RQ2] Uncorrected reversed idle level drives the receive output low.
// [RQ3] After the failsafe idle time with low idle, invert; receive output returns high.
// [RQ4] Detection starts at reset release; correction completes within 44 to 76 ms.
// [RQ5] Evaluation begins immediately while the direction control stays low.
// [RQ6] While corrected, every received bit is inverted toward the receive output.
// [RQ7] While corrected, host transmit data is inverted toward the bus driver.
// [RQ8] Every reset reruns detection and discards any previous polarity state.
// [RQ9] The master idles the bus longer than the maximum failsafe time first.
// [RQ10] Senders should avoid identical-bit runs longer than the minimum failsafe time.
// [RQ11] Tied enables act as direction control: high transmits, low receives.
// [RQ12] Standby only when driver and receiver are both disabled together.
// [RQ13] With receiver always on, receive output echoes the node's own transmission.
// [RQ14] Biased idle bus with no driver gives a high receive output.
// [RQ15] Detected polarity is latched and kept until the next reset.
// [RQ16] Detection runs only with receiver enabled and driver disabled.
// [RQ17] Standby entry needs both enables disabled for at least 300 ns.
// [RQ18] Idle counter on an internal time base restarts on level change; sets latch.
`default_nettype none
`timescale 1ns/1ps

module polarity_fix_logic #(
  parameter int FAILSAFE_TICKS = polarity_fix_pkg::FAILSAFE_MIN_TICKS,
  parameter int FIFO_DEPTH = polarity_fix_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Host side pins
  input wire logic driverOn,
  input wire logic receiverOn_n,
  input wire logic txData,
  output logic rxOut,
  output logic rxOutEn,
  // Bus side
  input wire logic busRx,
  output logic busTx,
  output logic busTxEn,
  // Status levels
  output logic standby,
  output logic polarityInverted
);
  localparam int IdleW = polarity_fix_pkg::IDLE_W;
  localparam int TickW = polarity_fix_pkg::TICK_W;
  localparam int StbyW = polarity_fix_pkg::STANDBY_W;
  localparam int GapW = polarity_fix_pkg::EVT_GAP_W;
  localparam int EvtW = polarity_fix_pkg::EVT_WIDTH;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic detectEn_reg;
  logic captureEn_reg;
  logic inverted_reg;
  logic busPrev_reg;
  logic [TickW-1:0] tickCount_reg;
  logic [IdleW-1:0] idleTicks_reg;
  logic [StbyW-1:0] stbyCount_reg;
  logic standby_reg;
  logic rxOut_reg;
  logic rxOutEn_reg;
  logic busTx_reg;
  logic busTxEn_reg;
  logic [GapW-1:0] gap_reg;
  logic pending_reg;
  logic [EvtW-1:0] pendWord_reg;
  logic overflow_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  logic detecting;
  logic tick;
  logic levelChanged;
  logic idleExpired;
  logic bothOff;
  logic rxNext;
  logic rxEdge;
  logic addrPhase;
  logic readEvent;
  logic writeStatus;
  logic fifoInReady;
  logic fifoOutValid;
  logic [EvtW-1:0] fifoOutData;
  logic [31:0] readMux;

  ////////////////////////////////////////////////////////////////////////////
  // Detection qualifiers
  // Window open only while listening with the driver off and nothing latched
  assign detecting = !driverOn && !receiverOn_n && detectEn_reg && !inverted_reg; // RQ16
  assign levelChanged = (busRx != busPrev_reg); // RQ18
  assign tick = (tickCount_reg == TickW'(polarity_fix_pkg::TICK_CYCLES - 1));
  assign idleExpired = (idleTicks_reg == IdleW'(FAILSAFE_TICKS));

  // Last bus level, used to restart the idle measurement
  always_ff @(posedge clk) begin
    if (rst) begin
      busPrev_reg <= 1'b1;
    end else if (ce) begin
      busPrev_reg <= busRx;
    end
  end

  // Internal time base, one tick per microsecond
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCount_reg <= '0;
    end else if (ce) begin
      if (!detecting || levelChanged || tick) begin // RQ18
        tickCount_reg <= '0;
      end else begin
        tickCount_reg <= tickCount_reg + 1'b1;
      end
    end
  end

  // Idle duration in ticks, saturating at the failsafe idle time
  always_ff @(posedge clk) begin
    if (rst) begin
      idleTicks_reg <= '0; // RQ8
    end else if (ce) begin
      if (!detecting || levelChanged) begin // RQ18
        idleTicks_reg <= '0;
      end else if (tick && !idleExpired) begin
        idleTicks_reg <= idleTicks_reg + 1'b1; // RQ5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Polarity latch
  // Set once on a low idle after the failsafe time; only reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      inverted_reg <= 1'b0; // RQ1 RQ8
    end else if (ce) begin
      if (detecting && idleExpired && !busRx && !levelChanged) begin
        inverted_reg <= 1'b1; // RQ3 RQ4 RQ18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standby qualification
  assign bothOff = !driverOn && receiverOn_n; // RQ12

  // Counts continuous disabled cycles; any enable restarts it
  always_ff @(posedge clk) begin
    if (rst) begin
      stbyCount_reg <= '0;
      standby_reg <= 1'b0;
    end else if (ce) begin
      if (!bothOff) begin
        stbyCount_reg <= '0;
        standby_reg <= 1'b0;
      end else if (stbyCount_reg == StbyW'(polarity_fix_pkg::STANDBY_CYCLES - 1)) begin
        standby_reg <= 1'b1; // RQ17
      end else begin
        stbyCount_reg <= stbyCount_reg + 1'b1; // RQ17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data paths
  // Bus level follows the idle bias and any driver, own driver included
  assign rxNext = busRx ^ inverted_reg; // RQ2 RQ6 RQ13 RQ14

  // Receive output, held while the receiver is off
  always_ff @(posedge clk) begin
    if (rst) begin
      rxOut_reg <= 1'b1;
      rxOutEn_reg <= 1'b0;
    end else if (ce) begin
      rxOutEn_reg <= !receiverOn_n;
      if (!receiverOn_n) begin
        rxOut_reg <= rxNext; // RQ6
      end
    end
  end

  // Transmit path; driver enable is a registered copy of its pin, one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      busTx_reg <= 1'b1;
      busTxEn_reg <= 1'b0;
    end else if (ce) begin
      busTx_reg <= txData ^ inverted_reg; // RQ7
      busTxEn_reg <= driverOn; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive edge capture into the FIFO
  assign rxEdge = !receiverOn_n && (rxNext != rxOut_reg) && captureEn_reg;

  // Cycles since the previous receive edge, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_reg <= '0;
    end else if (ce) begin
      if (rxEdge) begin
        gap_reg <= '0;
      end else if (gap_reg != '1) begin
        gap_reg <= gap_reg + 1'b1;
      end
    end
  end

  // One pending word waits while the FIFO is full
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_reg <= 1'b0;
      pendWord_reg <= '0;
    end else if (ce) begin
      if (rxEdge && (!pending_reg || fifoInReady)) begin
        pending_reg <= 1'b1;
        pendWord_reg <= {rxNext, gap_reg};
      end else if (pending_reg && fifoInReady) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Lost edge flag; a new loss wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_reg <= 1'b0;
    end else if (ce) begin
      if (rxEdge && pending_reg && !fifoInReady) begin
        overflow_reg <= 1'b1;
      end else if (writeStatus && hwdata[polarity_fix_pkg::STAT_OVERFLOW_BIT]) begin
        overflow_reg <= 1'b0;
      end
    end
  end

  stream_fifo #(
    .WIDTH(EvtW),
    .DEPTH(FIFO_DEPTH)
  ) eventFifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .inValid(pending_reg),
    .inReady(fifoInReady),
    .inData(pendWord_reg),
    .outValid(fifoOutValid),
    .outReady(readEvent),
    .outData(fifoOutData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  assign addrPhase = hsel && htrans[1] && hready && ce;
  assign readEvent = addrPhase && !hwrite && (haddr[7:0] == polarity_fix_pkg::RX_EVENT_OFS);
  assign writeStatus = wrPend_reg && (wrAddr_reg == polarity_fix_pkg::STATUS_OFS);

  // Read data selection at the address phase
  always_comb begin
    readMux = 32'h0000_0000;
    unique case (haddr[7:0])
      polarity_fix_pkg::CONTROL_OFS: begin
        readMux[polarity_fix_pkg::CTRL_DETECT_EN_BIT] = detectEn_reg;
        readMux[polarity_fix_pkg::CTRL_CAPTURE_EN_BIT] = captureEn_reg;
      end
      polarity_fix_pkg::STATUS_OFS: begin
        readMux[polarity_fix_pkg::STAT_INVERTED_BIT] = inverted_reg;
        readMux[polarity_fix_pkg::STAT_STANDBY_BIT] = standby_reg;
        readMux[polarity_fix_pkg::STAT_DETECTING_BIT] = detecting;
        readMux[polarity_fix_pkg::STAT_OVERFLOW_BIT] = overflow_reg;
        readMux[polarity_fix_pkg::STAT_FIFO_VALID_BIT] = fifoOutValid;
      end
      polarity_fix_pkg::IDLE_COUNT_OFS: begin
        readMux[IdleW-1:0] = idleTicks_reg;
      end
      polarity_fix_pkg::RX_EVENT_OFS: begin
        readMux[EvtW-1:0] = fifoOutValid ? fifoOutData : '0;
        readMux[polarity_fix_pkg::EVT_VALID_BIT] = fifoOutValid;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  // Registered read data for the following data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata_reg <= readMux;
    end
  end

  // Write address held for the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else if (ce) begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase && hwrite) begin
        wrAddr_reg <= haddr[7:0];
      end
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      detectEn_reg <= polarity_fix_pkg::CTRL_DETECT_EN_RST; // RQ5
      captureEn_reg <= polarity_fix_pkg::CTRL_CAPTURE_EN_RST;
    end else if (ce && wrPend_reg && (wrAddr_reg == polarity_fix_pkg::CONTROL_OFS)) begin
      detectEn_reg <= hwdata[polarity_fix_pkg::CTRL_DETECT_EN_BIT];
      captureEn_reg <= hwdata[polarity_fix_pkg::CTRL_CAPTURE_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign rxOut = rxOut_reg;
  assign rxOutEn = rxOutEn_reg;
  assign busTx = busTx_reg;
  assign busTxEn = busTxEn_reg;
  assign standby = standby_reg; // RQ12
  assign polarityInverted = inverted_reg; // RQ15
endmodule : polarity_fix_logic

`default_nettype wire

// ===== polarity_fix_monitor.sv
// Purpose: Port checks of the polarity fix logic.
// Assumes: One clock, synchronous active-high rst.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module polarity_fix_monitor #(
  parameter int FAILSAFE_TICKS = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic driverOn,
  input wire logic receiverOn_n,
  input wire logic txData,
  input wire logic busRx,
  input wire logic rxOut,
  input wire logic rxOutEn,
  input wire logic busTx,
  input wire logic busTxEn,
  input wire logic standby,
  input wire logic polarityInverted
);
  localparam int MIN_RUN = (FAILSAFE_TICKS - 1) * 200;
  localparam int MAX_RUN = FAILSAFE_TICKS * 200 + 10;
  int lowRun;
  int offRun;
  ////////////////////////////////////////////////////////////////////////////
  // Quiet low bus run and both-disabled run
  always_ff @(posedge clk) begin
    lowRun <= (rst || !ce || busRx || driverOn || receiverOn_n) ? 0 : lowRun + 1;
    offRun <= (rst || !ce || driverOn || !receiverOn_n) ? 0 : offRun + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_reset_clear;
    disable iff (1'b0) rst |=> !polarityInverted && !standby;
  endproperty
  property p_latch_hold;
    polarityInverted |=> polarityInverted;
  endproperty
  property p_rx_path;
    ce && !receiverOn_n |=> rxOut == $past(busRx ^ polarityInverted);
  endproperty
  property p_tx_path;
    ce |=> busTx == $past(txData ^ polarityInverted) && busTxEn == $past(driverOn)
      && rxOutEn == !$past(receiverOn_n);
  endproperty
  property p_set_min;
    $rose(polarityInverted) |-> lowRun >= MIN_RUN;
  endproperty
  property p_set_max;
    lowRun == MAX_RUN |-> polarityInverted;
  endproperty
  property p_stby_min;
    $rose(standby) |-> offRun >= polarity_fix_pkg::STANDBY_CYCLES;
  endproperty
  property p_stby_exit;
    standby && ce && (driverOn || !receiverOn_n) |=> !standby;
  endproperty
  property p_status_read;
    hsel && htrans[1] && hready && ce && !hwrite && haddr[7:0] == polarity_fix_pkg::STATUS_OFS
      |=> hrdata[0] == $past(polarityInverted) && hrdata[1] == $past(standby);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("latch or standby set after reset");
  a_latch_hold: assert property (p_latch_hold)
    else $error("correction latch cleared");
  a_rx_path: assert property (p_rx_path)
    else $error("receive output wrong");
  a_tx_path: assert property (p_tx_path)
    else $error("transmit path or enables wrong");
  a_set_min: assert property (p_set_min)
    else $error("correction set too early");
  a_set_max: assert property (p_set_max)
    else $error("correction set too late");
  a_stby_min: assert property (p_stby_min)
    else $error("standby entered too soon");
  a_stby_exit: assert property (p_stby_exit)
    else $error("standby kept while enabled");
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");
  c_corrected: cover property ($rose(polarityInverted));
  c_standby: cover property ($rose(standby));
  c_echo: cover property (driverOn && !receiverOn_n ##1 busTxEn);
endmodule : polarity_fix_monitor

bind polarity_fix_logic polarity_fix_monitor #(.FAILSAFE_TICKS(FAILSAFE_TICKS))
  u_polarity_fix_monitor (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .driverOn(driverOn),
  .receiverOn_n(receiverOn_n), .txData(txData), .busRx(busRx), .rxOut(rxOut),
  .rxOutEn(rxOutEn), .busTx(busTx), .busTxEn(busTxEn), .standby(standby),
  .polarityInverted(polarityInverted));
`default_nettype wire

// ===== bus_master_node.sv
// Purpose: Master node with failsafe bias and an optional cross-wired pair.
// Assumes: Node driver and master never drive together.
// Notes:   Idle bus rests at the biased high level.
`timescale 1ns/1ps
`default_nettype none
module bus_master_node (
  input wire logic crossWire,
  input wire logic masterOn,
  input wire logic masterBit,
  input wire logic busTx,
  input wire logic busTxEn,
  output logic busRx,
  output logic farLevel
);
  logic pairLevel;
  // Level at the master end; bias pulls an undriven pair high
  assign pairLevel = busTxEn ? (busTx ^ crossWire) : (masterOn ? masterBit : 1'h1);
  // Node sees the pair through the fault
  assign busRx = pairLevel ^ crossWire;
  assign farLevel = pairLevel;
endmodule : bus_master_node
`default_nettype wire

// ===== bus_polarity_correction_test.sv
// Purpose: Self-checking bench of the polarity fix logic.
// Assumes: Short failsafe count, master model on the bus side.
// Notes:   Expected values come from mInv and levelQ.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin nFail++; \
  $display("BAD %s expected %0h seen %0h", n, e, g); end end
module bus_polarity_correction_test;
  localparam int FS = 20;
  localparam int WMAX = FS * 200 + 50;
  logic clk, rst, ce, hsel, hwrite, driverOn, receiverOn_n, txData, crossWire, masterOn;
  logic masterBit, hready, hreadyout, hresp, rxOut, rxOutEn, busRx, busTx, busTxEn;
  logic standby, polarityInverted, farLevel, b;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int nFail = 0, numChecks = 0, cycles = 0, seed = 32'hdfe2, mInv, cnt;
  int levelQ[$];
  polarity_fix_logic #(.FAILSAFE_TICKS(FS), .FIFO_DEPTH(16)) u_polarity_fix_logic (
    .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .driverOn(driverOn), .receiverOn_n(receiverOn_n),
    .txData(txData), .rxOut(rxOut), .rxOutEn(rxOutEn), .busRx(busRx), .busTx(busTx),
    .busTxEn(busTxEn), .standby(standby), .polarityInverted(polarityInverted));
  bus_master_node u_bus_master_node (.crossWire(crossWire), .masterOn(masterOn),
    .masterBit(masterBit), .busTx(busTx), .busTxEn(busTxEn), .busRx(busRx),
    .farLevel(farLevel));
  assign hready = hreadyout;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      nFail++;
      completeRun();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
    `CHK("hresp", 1'h0, hresp)
  endtask : ahb
  task automatic powerUp(input logic cw);
    @(posedge clk);
    rst <= 1'h1;
    crossWire <= cw;
    driverOn <= 1'h0;
    receiverOn_n <= 1'h0;
    masterOn <= 1'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    mInv = 0;
  endtask : powerUp
  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : completeRun
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ce, hsel, hwrite, driverOn, receiverOn_n, txData} = 7'h61;
    {crossWire, masterOn, masterBit, htrans, haddr, hwdata} = '0;
    // Straight pair: registers, then a long idle
    powerUp(1'h0);
    ahb(1'h0, polarity_fix_pkg::CONTROL_OFS, 32'h0);
    `CHK("control reset", 32'h3, rd)
    ahb(1'h1, polarity_fix_pkg::CONTROL_OFS, 32'h2);
    ahb(1'h0, polarity_fix_pkg::CONTROL_OFS, 32'h0);
    `CHK("control write", 32'h2, rd)
    ahb(1'h1, polarity_fix_pkg::CONTROL_OFS, 32'h3);
    ahb(1'h0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    cyc(FS * 400);
    `CHK("no correction", 1'h0, polarityInverted)
    `CHK("idle high", 1'h1, rxOut)
    ahb(1'h0, polarity_fix_pkg::IDLE_COUNT_OFS, 32'h0);
    `CHK("idle ticks", FS, rd)
    ahb(1'h0, polarity_fix_pkg::STATUS_OFS, 32'h0);
    `CHK("status idle", 32'h4, rd)
    $display("test straight idle done");
    // Crossed pair: low first, then corrected inside the window
    powerUp(1'h1);
    cyc(3);
    `CHK("reversed idle", 1'h0, rxOut)
    cnt = 0;
    while (polarityInverted !== 1'h1 && cnt < WMAX) begin
      cyc(1);
      cnt++;
    end
    `CHK("window", 1'h1, cnt >= (FS - 1) * 200 && cnt < WMAX)
    mInv = 1;
    cyc(2);
    `CHK("corrected idle", 1'h1, rxOut)
    ahb(1'h0, polarity_fix_pkg::STATUS_OFS, 32'h0);
    `CHK("status inv", 1'h1, rd[0])
    for (int i = 0; i < 8; i++) begin
      b = 1'($random(seed));
      @(posedge clk);
      driverOn <= 1'h1;
      txData <= b;
      cyc(2);
      `CHK("busTx", b ^ mInv[0], busTx)
      `CHK("far end", b, farLevel)
      `CHK("echo", b, rxOut)
    end
    // Master idled past the failsafe time; short random runs follow
    for (int i = 0; i < 8; i++) begin
      b = 1'($random(seed));
      @(posedge clk);
      driverOn <= 1'h0;
      masterOn <= 1'h1;
      masterBit <= b;
      cyc(2);
      `CHK("rx data", b ^ crossWire ^ mInv[0], rxOut)
    end
    `CHK("latch kept", 1'h1, polarityInverted)
    $display("test crossed pair done");
    // Standby needs a long both-disabled spell
    @(posedge clk);
    masterOn <= 1'h0;
    receiverOn_n <= 1'h1;
    cyc(30);
    @(posedge clk);
    receiverOn_n <= 1'h0;
    cyc(2);
    `CHK("short off", 1'h0, standby)
    @(posedge clk);
    receiverOn_n <= 1'h1;
    ce <= 1'h0;
    cyc(70);
    `CHK("frozen", 1'h0, standby)
    @(posedge clk);
    ce <= 1'h1;
    cyc(70);
    `CHK("standby", 1'h1, standby)
    @(posedge clk);
    driverOn <= 1'h1;
    cyc(2);
    `CHK("tx mode", 3'h2, {standby, busTxEn, rxOutEn})
    @(posedge clk);
    {driverOn, receiverOn_n} <= 2'h0;
    cyc(2);
    `CHK("rx mode", 2'h1, {busTxEn, rxOutEn})
    $display("test enables done");
    // Rerun after power-up; driving blocks detection
    powerUp(1'h1);
    @(posedge clk);
    driverOn <= 1'h1;
    txData <= 1'h0;
    cyc(FS * 400);
    `CHK("cleared", 1'h0, polarityInverted)
    @(posedge clk);
    driverOn <= 1'h0;
    cyc(WMAX);
    `CHK("rerun", 1'h1, polarityInverted)
    $display("test rerun done");
    // Event buffer: overfill, then drain in order
    powerUp(1'h0);
    levelQ.delete();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      masterOn <= 1'h1;
      masterBit <= i[0];
      levelQ.push_back(i % 2);
      repeat (3) @(posedge clk);
    end
    cyc(4);
    ahb(1'h0, polarity_fix_pkg::STATUS_OFS, 32'h0);
    `CHK("overflow", 2'h3, rd[4:3])
    cnt = 0;
    do begin
      ahb(1'h0, polarity_fix_pkg::RX_EVENT_OFS, 32'h0);
      if (rd[16]) `CHK("event level", levelQ[cnt][0], rd[15])
      if (rd[16] && cnt > 0) `CHK("event gap", 15'h3, rd[14:0])
      cnt++;
    end while (rd[16] === 1'h1 && cnt < 20);
    `CHK("drained", polarity_fix_pkg::FIFO_DEPTH + 2, cnt)
    ahb(1'h1, polarity_fix_pkg::STATUS_OFS, 32'h8);
    ahb(1'h0, polarity_fix_pkg::STATUS_OFS, 32'h0);
    `CHK("overflow clear", 2'h0, rd[4:3])
    $display("test buffer done");
    completeRun();
  end
endmodule : bus_polarity_correction_test
`default_nettype wire
